// file: rtl/smfs_defs.svh
// Constants of the safety mode and fault supervisor
`ifndef SMFS_DEFS_SVH
`define SMFS_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define SMFS_CLK_PERIOD_NS 8.0
`define SMFS_NS_PER_MS     1.0e6
`define SMFS_APP_CYCLE_MS  2.5
`define SMFS_LINK_TMO_MS   5.0

// ****************************************************************
// Fault levels, fault sources, platform state
// ****************************************************************
`define SMFS_FT_NONE  2'h0
`define SMFS_FT_III   2'h1
`define SMFS_FT_II    2'h2
`define SMFS_FT_I     2'h3
`define SMFS_SRC_NONE 2'h0
`define SMFS_SRC_IN   2'h1
`define SMFS_SRC_OUT  2'h2
`define SMFS_SRC_SELF 2'h3
`define SMFS_LVL_LAN  2'h2
`define SMFS_PLAT_OK   2'h0
`define SMFS_PLAT_DEGR 2'h1
`define SMFS_PLAT_FAIL 2'h2

// ****************************************************************
// Synchronised pin positions
// ****************************************************************
`define SMFS_NPINS    6
`define SMFS_PIN_PWR  0
`define SMFS_PIN_SEAT 1
`define SMFS_PIN_PSU  2
`define SMFS_PIN_TUNE 3
`define SMFS_PIN_ARM  4
`define SMFS_PIN_LAN  5

`endif

// file: rtl/smfs_pkg.sv
// Types of the safety mode and fault supervisor
package smfs_pkg;
  // Operating modes
  typedef enum logic [2:0] {
    SMFS_UNPOWERED,
    SMFS_POWER_UP,
    SMFS_RUN,
    SMFS_SAFE_RUN,
    SMFS_TUNING,
    SMFS_FAULT_HALT,
    SMFS_CONFIG
  } smfs_mode_type;
  // Phases of one processing cycle
  typedef enum logic [1:0] {
    SMFS_PH_RECEIVE,
    SMFS_PH_PROCESS,
    SMFS_PH_TRANSMIT,
    SMFS_PH_SWITCH
  } smfs_phase_type;
endpackage

// file: rtl/smfs_link_if.sv
// Carrier between the supervisor and its link monitor
`timescale 1ns/1ps
interface smfs_link_if #(
  parameter int N = 8
) ();
  logic         enable;   // Links active
  logic [N-1:0] rx_seen;  // Frame received per module
  logic [N-1:0] lost;     // Link lost per module
  modport sup (output enable, output rx_seen, input lost);
  modport mon (input enable, input rx_seen, output lost);
endinterface

// file: rtl/smfs_link_mon.sv
// Per-module link loss detector
`timescale 1ns/1ps
`include "smfs_defs.svh"
module smfs_link_mon
  import smfs_pkg::*;
#(
  parameter int N   = 8,
  parameter int TMO = 625000
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Link status carrier
  smfs_link_if.mon  lnk
);

  localparam int CW = $clog2(TMO + 1);

  logic [CW-1:0] cnt_q [N];  // Silence counters
  logic [N-1:0]  lost_q;     // Sticky loss flags

  // ****************************************************************
  // Silence counters and loss flags
  // ****************************************************************
  // A module silent for the timeout is lost until links drop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lost_q <= '0;
      for (int i = 0; i < N; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (!lnk.enable) begin
          // Links idle: forget old state
          cnt_q[i]  <= '0;
          lost_q[i] <= 1'b0;
        end else if (lnk.rx_seen[i]) begin
          cnt_q[i] <= '0;
        end else if (cnt_q[i] == CW'(TMO - 1)) begin
          lost_q[i] <= 1'b1;
        end else begin
          cnt_q[i] <= cnt_q[i] + CW'(1);
        end
      end
    end
  end

  assign lnk.lost = lost_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  lost_sets_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      lnk.enable && !lnk.rx_seen[0] && cnt_q[0] == CW'(TMO - 1)
      |=> lost_q[0])
    else $error("silent module not flagged lost");
  lost_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !lnk.enable |=> lost_q == '0)
    else $error("loss flag survived link shutdown");

endmodule

// file: rtl/smfs_supervisor.sv
// Operating mode and fault response supervisor, top level
`timescale 1ns/1ps
`include "smfs_defs.svh"
module smfs_supervisor
  import smfs_pkg::*;
#(
  parameter int          N_IO     = 8,
  parameter int          DATA_W   = 16,
  parameter int          N_OUT    = 6,
  parameter logic [5:0]  SAFE_OUT = 6'h00,
  parameter int          APP_CYCLE_CLKS =
    int'(`SMFS_APP_CYCLE_MS * `SMFS_NS_PER_MS / `SMFS_CLK_PERIOD_NS),
  parameter int          LINK_TMO_CLKS  =
    int'(`SMFS_LINK_TMO_MS * `SMFS_NS_PER_MS / `SMFS_CLK_PERIOD_NS)
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  // Pins from outside the clock domain
  input  wire logic                     power_good_i,
  input  wire logic                     seated_i,
  input  wire logic                     psu_fault_i,
  input  wire logic                     tune_key_i,
  input  wire logic                     arm_key_i,
  input  wire logic                     lan_up_i,
  // Mode control from on-chip logic
  input  wire logic                     power_up_mode_done_i,
  input  wire logic                     safe_output_request_i,
  input  wire logic                     app_safe_req_i,
  input  wire logic                     cfg_req_i,
  input  wire logic                     cfg_done_i,
  input  wire logic                     phase_done_i,
  // Diagnostics
  input  wire logic [1:0]               self_fault_i,
  input  wire logic [1:0]               in_fault_i,
  input  wire logic [1:0]               out_fault_i,
  input  wire logic                     crc_fail_i,
  // Change requests for configuration or tuning
  input  wire logic                     chg_req_i,
  input  wire logic                     chg_is_tune_i,
  output logic                          chg_ack_o,
  output logic                          chg_nak_o,
  // Module links
  input  wire logic [N_IO-1:0]          rx_valid_i,
  input  wire logic [N_IO*DATA_W-1:0]   rx_data_i,
  output logic [N_IO*DATA_W-1:0]        rx_data_o,
  output logic                          link_en_o,
  output logic                          trip_o,
  output logic [N_IO-1:0]               module_lost_o,
  // Field outputs
  input  wire logic [N_OUT-1:0]         out_req_i,
  output logic [N_OUT-1:0]              field_out_o,
  output logic                          field_conn_o,
  // Status
  output logic [2:0]                    mode_o,
  output logic [1:0]                    phase_o,
  output logic                          heartbeat_o,
  output logic [7:0]                    ind_code_o,
  output logic [7:0]                    mnt_code_o,
  output logic [1:0]                    platform_o,
  output logic                          lan_fail_o,
  output logic [1:0]                    in_fault_o,
  output logic [1:0]                    out_fault_o
);

  localparam int CCW = $clog2(APP_CYCLE_CLKS + 1);

  logic [`SMFS_NPINS-1:0] sync1_q;    // First synchroniser stage
  logic [`SMFS_NPINS-1:0] sync2_q;    // Second synchroniser stage
  logic                   pwr, seat, psu, tune, arm, lan;
  smfs_mode_type          mode_q, mode_d;  // Operating mode
  smfs_phase_type         phase_q;    // Processing phase
  logic [CCW-1:0]         cyc_q;      // Cycle time counter
  logic                   proc_on;    // Processing active
  logic                   overrun;    // Cycle too long
  logic                   hb_stop_q;  // Heartbeat frozen
  logic [1:0]             err_lvl_q;  // Worst level so far
  logic [1:0]             err_src_q;  // Its source
  logic [1:0]             cand_lvl;   // Worst level now
  logic [1:0]             cand_src;
  logic                   link_on;
  logic [7:0]             code;

  smfs_link_if #(.N(N_IO)) lnk ();

  smfs_link_mon #(
    .N   (N_IO),
    .TMO (LINK_TMO_CLKS)
  ) u_link_mon (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .lnk     (lnk)
  );

  // Escalation of an I/O module fault; lesser ones go to app logic
  function automatic logic [1:0] smfs_escalate(input logic [1:0] f);
    smfs_escalate = (f == `SMFS_FT_I) ? f : `SMFS_FT_NONE;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {lan_up_i, arm_key_i, tune_key_i,
                  psu_fault_i, seated_i, power_good_i};
      sync2_q <= sync1_q;
    end
  end

  assign pwr  = sync2_q[`SMFS_PIN_PWR];
  assign seat = sync2_q[`SMFS_PIN_SEAT];
  assign psu  = sync2_q[`SMFS_PIN_PSU];
  assign tune = sync2_q[`SMFS_PIN_TUNE];
  assign arm  = sync2_q[`SMFS_PIN_ARM];
  assign lan  = sync2_q[`SMFS_PIN_LAN];

  // ****************************************************************
  // Mode sequencer
  // ****************************************************************
  // Next mode; power loss beats every other cause
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      SMFS_UNPOWERED: begin
        if (pwr) mode_d = SMFS_POWER_UP;
      end
      SMFS_POWER_UP: begin
        if (power_up_mode_done_i) mode_d = SMFS_RUN;
      end
      SMFS_RUN: begin
        if (app_safe_req_i) mode_d = SMFS_SAFE_RUN;
      end
      SMFS_SAFE_RUN: begin
        if (safe_output_request_i && app_safe_req_i && tune && arm) begin
          mode_d = SMFS_TUNING;
        end else if (cfg_req_i) begin
          mode_d = SMFS_CONFIG;
        end else if (!app_safe_req_i) begin
          mode_d = SMFS_RUN;
        end
      end
      SMFS_TUNING: begin
        // Password checking is the maintenance station's job
        if (!(tune && arm)) mode_d = SMFS_SAFE_RUN;
      end
      SMFS_CONFIG: begin
        if (cfg_done_i) mode_d = SMFS_POWER_UP;
      end
      SMFS_FAULT_HALT: begin
        mode_d = SMFS_FAULT_HALT;
      end
      default: begin
        mode_d = SMFS_FAULT_HALT;
      end
    endcase
    if (mode_q != SMFS_UNPOWERED && (psu || hb_stop_q)) begin
      mode_d = SMFS_FAULT_HALT;
    end
    if (!pwr) mode_d = SMFS_UNPOWERED;
  end

  // Mode register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) mode_q <= SMFS_UNPOWERED;
    else          mode_q <= mode_d;
  end

  // ****************************************************************
  // Processing cycle
  // ****************************************************************
  assign proc_on = (mode_q == SMFS_POWER_UP) || (mode_q == SMFS_RUN) ||
                   (mode_q == SMFS_SAFE_RUN) || (mode_q == SMFS_TUNING);
  assign overrun = proc_on && (cyc_q == CCW'(APP_CYCLE_CLKS - 1)) &&
                   !(phase_q == SMFS_PH_SWITCH && phase_done_i);

  // Four phases in fixed order, cycle time counted
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= SMFS_PH_RECEIVE;
      cyc_q   <= '0;
    end else if (!proc_on) begin
      phase_q <= SMFS_PH_RECEIVE;
      cyc_q   <= '0;
    end else begin
      cyc_q <= (cyc_q == CCW'(APP_CYCLE_CLKS - 1)) ? cyc_q
                                                   : cyc_q + CCW'(1);
      if (phase_done_i) begin
        case (phase_q)
          SMFS_PH_RECEIVE:  phase_q <= SMFS_PH_PROCESS;
          SMFS_PH_PROCESS:  phase_q <= SMFS_PH_TRANSMIT;
          SMFS_PH_TRANSMIT: phase_q <= SMFS_PH_SWITCH;
          default: begin
            phase_q <= SMFS_PH_RECEIVE;
            cyc_q   <= '0;
          end
        endcase
      end
    end
  end

  // Heartbeat toggles at each completed cycle until frozen
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      heartbeat_o <= 1'b0;
      hb_stop_q   <= 1'b0;
    end else if (mode_q == SMFS_UNPOWERED) begin
      hb_stop_q <= 1'b0;
    end else begin
      if (crc_fail_i) hb_stop_q <= 1'b1;
      if (overrun) hb_stop_q <= 1'b1;
      if (self_fault_i == `SMFS_FT_I && phase_q == SMFS_PH_PROCESS &&
          proc_on) begin
        hb_stop_q <= 1'b1;
      end
      if (!hb_stop_q && proc_on && phase_q == SMFS_PH_SWITCH &&
          phase_done_i) begin
        heartbeat_o <= ~heartbeat_o;
      end
    end
  end

  // ****************************************************************
  // Links and field outputs
  // ****************************************************************
  assign link_on = pwr && seat && mode_q != SMFS_UNPOWERED &&
                   mode_q != SMFS_FAULT_HALT;
  assign lnk.enable  = link_en_o;
  assign lnk.rx_seen = rx_valid_i & {N_IO{link_en_o}};

  // Link enable, trip flag and per-module state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_en_o     <= 1'b0;
      trip_o        <= 1'b0;
      module_lost_o <= '0;
    end else begin
      link_en_o     <= link_on;
      trip_o        <= |lnk.lost;
      module_lost_o <= lnk.lost;
    end
  end

  // Received data, zeroed for lost or idle links
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_data_o <= '0;
    end else begin
      for (int i = 0; i < N_IO; i++) begin
        if (!link_en_o || lnk.lost[i]) begin
          rx_data_o[i*DATA_W +: DATA_W] <= '0;
        end else if (rx_valid_i[i]) begin
          rx_data_o[i*DATA_W +: DATA_W] <= rx_data_i[i*DATA_W +: DATA_W];
        end
      end
    end
  end

  // Field outputs driven only in run with healthy links
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      field_out_o  <= SAFE_OUT;
      field_conn_o <= 1'b0;
    end else begin
      if (mode_q == SMFS_RUN && link_en_o && !(|lnk.lost)) begin
        field_out_o <= out_req_i;
      end else begin
        field_out_o <= SAFE_OUT;
      end
      field_conn_o <= seat && pwr;
    end
  end

  // Change requests, refused outside the matching mode
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chg_ack_o <= 1'b0;
      chg_nak_o <= 1'b0;
    end else begin
      chg_ack_o <= chg_req_i && mode_q != SMFS_UNPOWERED &&
                   (chg_is_tune_i ? mode_q == SMFS_TUNING
                                  : mode_q == SMFS_CONFIG);
      chg_nak_o <= chg_req_i && (mode_q == SMFS_UNPOWERED ||
                   (chg_is_tune_i ? mode_q != SMFS_TUNING
                                  : mode_q != SMFS_CONFIG));
    end
  end

  // ****************************************************************
  // Fault classification and reporting
  // ****************************************************************
  // Worst present fault across the three classes
  always_comb begin
    cand_lvl = self_fault_i;
    cand_src = (self_fault_i != `SMFS_FT_NONE) ? `SMFS_SRC_SELF
                                                : `SMFS_SRC_NONE;
    if (smfs_escalate(in_fault_i) > cand_lvl) begin
      cand_lvl = smfs_escalate(in_fault_i);
      cand_src = `SMFS_SRC_IN;
    end
    if (smfs_escalate(out_fault_i) > cand_lvl) begin
      cand_lvl = smfs_escalate(out_fault_i);
      cand_src = `SMFS_SRC_OUT;
    end
  end

  // Error latch and network loss, held until power-off
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_lvl_q  <= `SMFS_FT_NONE;
      err_src_q  <= `SMFS_SRC_NONE;
      lan_fail_o <= 1'b0;
    end else if (mode_q == SMFS_UNPOWERED) begin
      err_lvl_q  <= `SMFS_FT_NONE;
      err_src_q  <= `SMFS_SRC_NONE;
      lan_fail_o <= 1'b0;
    end else begin
      if (cand_lvl > err_lvl_q) begin
        err_lvl_q <= cand_lvl;
        err_src_q <= cand_src;
      end
      if (proc_on && !lan) lan_fail_o <= 1'b1;
    end
  end

  assign code = {mode_q, lan_fail_o, err_src_q, err_lvl_q};

  // Status to indicator board and maintenance link
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ind_code_o  <= '0;
      mnt_code_o  <= '0;
      platform_o  <= `SMFS_PLAT_OK;
      mode_o      <= '0;
      phase_o     <= '0;
      in_fault_o  <= `SMFS_FT_NONE;
      out_fault_o <= `SMFS_FT_NONE;
    end else begin
      ind_code_o  <= code;
      mnt_code_o  <= code;
      mode_o      <= mode_q;
      phase_o     <= phase_q;
      in_fault_o  <= in_fault_i;
      out_fault_o <= out_fault_i;
      if (err_lvl_q == `SMFS_FT_I || mode_q == SMFS_FAULT_HALT) begin
        platform_o <= `SMFS_PLAT_FAIL;
      end else if (err_lvl_q != `SMFS_FT_NONE || trip_o || lan_fail_o) begin
        platform_o <= `SMFS_PLAT_DEGR;
      end else begin
        platform_o <= `SMFS_PLAT_OK;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_tune_keys;
    safe_output_request_i && app_safe_req_i && tune && arm;
  endsequence
  sequence s_tune_step;
    mode_q == SMFS_SAFE_RUN ##1 mode_q == SMFS_TUNING;
  endsequence

  unpowered_safe_a: assert property (
      mode_q == SMFS_UNPOWERED |=> field_out_o == SAFE_OUT && !link_en_o)
    else $error("outputs not safe while unpowered");
  unpowered_nak_a: assert property (
      chg_req_i && mode_q == SMFS_UNPOWERED |=> chg_nak_o && !chg_ack_o)
    else $error("change accepted while unpowered");
  wake_up_a: assert property (
      mode_q == SMFS_UNPOWERED && pwr |=> mode_q == SMFS_POWER_UP)
    else $error("energizing did not enter power-up");
  power_loss_a: assert property (
      !pwr |=> mode_q == SMFS_UNPOWERED)
    else $error("power loss did not reach unpowered");
  tune_entry_a: assert property (
      s_tune_step |-> $past(safe_output_request_i && app_safe_req_i) &&
      $past(tune && arm))
    else $error("tuning entered without its conditions");
  phase_order_a: assert property (
      proc_on && phase_q == SMFS_PH_RECEIVE && phase_done_i &&
      mode_d == mode_q |=> phase_q == SMFS_PH_PROCESS)
    else $error("phase order broken");
  err_hold_a: assert property (
      mode_q != SMFS_UNPOWERED && err_lvl_q != `SMFS_FT_NONE
      |=> err_lvl_q >= $past(err_lvl_q) || mode_q == SMFS_UNPOWERED)
    else $error("error report dropped");
  psu_halt_a: assert property (
      pwr && psu && mode_q != SMFS_UNPOWERED
      |=> mode_q == SMFS_FAULT_HALT ##1 field_out_o == SAFE_OUT)
    else $error("watchdog failure did not halt safely");
  hb_freeze_a: assert property (
      hb_stop_q |=> $stable(heartbeat_o))
    else $error("heartbeat moved after freeze");
  lost_zero_a: assert property (
      lnk.lost[0] |=> rx_data_o[DATA_W-1:0] == '0)
    else $error("lost module data not zeroed");
  trip_flag_a: assert property (
      |lnk.lost |=> trip_o ##1 field_out_o == SAFE_OUT)
    else $error("trip flag not raised");

endmodule

// file: testbench/smfs_chassis_model.sv
// Chassis I/O modules and power-supply watchdog model
`timescale 1ns/1ps
module smfs_chassis_model #(
  parameter int N      = 8,
  parameter int WD_TMO = 200
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // From the supervisor
  input  wire logic          pwr_i,
  input  wire logic          hb_i,
  input  wire logic          link_en_i,
  input  wire logic          trip_i,
  // Test controls
  input  wire logic [N-1:0]  mute_i,
  input  wire logic [15:0]   data_i,
  // To the supervisor and the bench
  output logic [N-1:0]       rx_valid_o,
  output logic [N*16-1:0]    rx_data_o,
  output logic               psu_fault_o,
  output logic               out_safe_o,
  output logic               comm_lost_o
);
  int   cnt;   // Cycles since the last heartbeat edge
  int   tick;  // Frame spacing
  logic hb_q;  // Last heartbeat level
  // Watchdog: a stale heartbeat reports a power failure
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i || !pwr_i) begin
      cnt <= 0;
      psu_fault_o <= 1'b0;
    end else if (hb_i != hb_q) begin
      cnt <= 0;
    end else if (cnt >= WD_TMO) begin
      psu_fault_o <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
  always @(posedge clk_i) hb_q <= hb_i;
  // Modules answer every 8 cycles; idle data lines show the inverse
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick <= 0;
      rx_valid_o <= '0;
      rx_data_o <= '0;
    end else begin
      tick <= (tick + 1) % 8;
      for (int i = 0; i < N; i++) begin
        rx_valid_o[i] <= (tick == 0) && !mute_i[i];
        rx_data_o[i*16+:16] <= (tick == 0) ? data_i : ~data_i;
      end
    end
  end
  // Output modules: silence sets the comm-lost and safe channels, a trip sets the safe channel only
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_safe_o  <= 1'b1;
      comm_lost_o <= 1'b1;
    end else begin
      comm_lost_o <= !link_en_i;
      out_safe_o  <= trip_i || !link_en_i;
    end
  end
endmodule

// file: testbench/smfs_supervisor_tb.sv
// Testbench of the safety mode and fault supervisor
`timescale 1ns/1ps
module smfs_supervisor_tb;
  import smfs_pkg::*;
  logic clk_i = 0, rst_n_i = 0, pwr = 0, seat = 1, tune = 0, arm = 0;
  logic lan = 1, sdone = 0, sreq = 0, asor = 0, phd = 0, crc = 0;
  logic creq = 0, ctune = 0, run_ph = 0, h0, ack, nak, len, trip, hb;
  logic fc, lf, ps, osafe, clost, cfg = 0, cdone = 0;
  logic [1:0] sf = 0, inf = 0, outf = 0, ph, pph, plat, inf_o, outf_o;
  logic [2:0] mode, pm;
  logic [7:0] mute = 0, rxv, lost, ind, mnt;
  logic [127:0] rxd, rxo;
  logic [15:0] dat = 16'h0000, pw;
  logic [5:0] req = 6'h00, fo;
  int error_cnt = 0, check_count = 0;
  smfs_supervisor #(.APP_CYCLE_CLKS(64), .LINK_TMO_CLKS(32)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .power_good_i(pwr),
    .seated_i(seat), .psu_fault_i(ps), .tune_key_i(tune),
    .arm_key_i(arm), .lan_up_i(lan), .power_up_mode_done_i(sdone),
    .safe_output_request_i(sreq), .app_safe_req_i(asor), .cfg_req_i(cfg),
    .cfg_done_i(cdone), .phase_done_i(phd), .self_fault_i(sf),
    .in_fault_i(inf), .out_fault_i(outf), .crc_fail_i(crc),
    .chg_req_i(creq), .chg_is_tune_i(ctune), .chg_ack_o(ack),
    .chg_nak_o(nak), .rx_valid_i(rxv), .rx_data_i(rxd),
    .rx_data_o(rxo), .link_en_o(len), .trip_o(trip),
    .module_lost_o(lost), .out_req_i(req), .field_out_o(fo),
    .field_conn_o(fc), .mode_o(mode), .phase_o(ph),
    .heartbeat_o(hb), .ind_code_o(ind), .mnt_code_o(mnt),
    .platform_o(plat), .lan_fail_o(lf), .in_fault_o(inf_o),
    .out_fault_o(outf_o));
  smfs_chassis_model u_chassis (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .pwr_i(pwr), .hb_i(hb), .link_en_i(len), .trip_i(trip),
    .mute_i(mute), .data_i(dat),
    .rx_valid_o(rxv), .rx_data_o(rxd), .psu_fault_o(ps),
    .out_safe_o(osafe), .comm_lost_o(clost));
  initial forever #4 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Bounded wait for a mode, then compare
  task automatic wmode(input logic [2:0] m);
    int k;
    k = 0;
    while (mode !== m && k < 100) begin
      cyc(1);
      k++;
    end
    chk(mode, m);
  endtask
  // Change request; answer comes one edge after it is taken
  task automatic chg(input logic t, input logic a);
    ctune = t;
    creq = 1;
    cyc(1);
    chk({ack, nak}, {a, ~a});
    creq = 0;
    cyc(1);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Phase done pulse every 4 cycles: one processing cycle is 16
  always begin
    cyc(3);
    phd = run_ph;
    cyc(1);
    phd = 0;
  end
  // Phases must step in order while in run mode
  always @(negedge clk_i) begin
    if (pm === 3'h2 && mode === 3'h2 && ph !== pph)
      chk(ph, 2'(pph + 2'h1));
    pph = ph;
    pm = mode;
  end
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
  initial begin
    dat = 16'($urandom(57871));
    req = 6'($urandom);
    cyc(16);
    rst_n_i = 1;
    cyc(4);
    chk({mode, len, fo, |rxo}, 0);
    chg(1, 0);
    chg(0, 0);
    pwr = 1;
    run_ph = 1;
    wmode(1);
    sdone = 1;
    wmode(2);
    cyc(20);
    chk({len, fc, fo}, {2'h3, req});
    chk({osafe, clost}, 0);
    chk(rxo[31:16], dat);
    h0 = hb;
    cyc(16);
    chk(hb, 1'(~h0));
    sf = 2;
    inf = 1;
    cyc(1);
    chk(inf_o, 1);
    sf = 1;
    inf = 0;
    cyc(3);
    chk(ind[3:0], 4'he);
    lan = 0;
    cyc(5);
    chk({lf, ind[4]}, 2'h3);
    chk({ind, mnt}, {2{8'h5e}});
    chk(plat, 1);
    // Output module type I fault replaces the lesser self fault
    outf = 3;
    cyc(1);
    chk(outf_o, 3);
    outf = 1;
    cyc(3);
    chk({ind[3:0], plat}, {4'hb, 2'h2});
    outf = 0;
    asor = 1;
    wmode(3);
    sreq = 1;
    tune = 1;
    cyc(6);
    chk(mode, 3);
    arm = 1;
    wmode(4);
    // Station sends tuning values only once the password matches
    pw = ~dat;
    if (pw == dat) chg(1, 1);
    chk({ack, nak}, 0);
    pw = dat;
    if (pw == dat) chg(1, 1);
    tune = 0;
    wmode(3);
    // Configuration mode accepts configuration values only
    cfg = 1;
    wmode(6);
    cfg = 0;
    asor = 0;
    chg(0, 1);
    chg(1, 0);
    cdone = 1;
    wmode(2);
    cdone = 0;
    mute = 8'h01;
    cyc(60);
    chk({lost, trip}, 9'h003);
    chk(rxo[31:0], {dat, 16'h0000});
    chk(fo, 0);
    chk(osafe, 1);
    seat = 0;
    cyc(4);
    chk({fc, clost, osafe}, 3'h3);
    crc = 1;
    cyc(1);
    crc = 0;
    wmode(5);
    h0 = hb;
    cyc(40);
    chk({hb, fo, ind[7:5]}, {h0, 6'h00, 3'h5});
    // Frozen heartbeat makes the watchdog report a failure
    cyc(180);
    chk({ps, mode}, {1'b1, 3'h5});
    pwr = 0;
    wmode(0);
    cyc(2);
    chk({len, fo}, 0);
    chg(0, 0);
    // Second power-up with phases stalled: cycle overrun halts
    run_ph = 0;
    pwr = 1;
    wmode(2);
    wmode(5);
    stop_test();
  end
endmodule
